// ### design/mcast_pkg.sv
// Constants and carrier types for the multicast capability register block.
package mcast_pkg;
	// Register offsets, as byte addresses of the configuration space.
	localparam logic [11:0] OFS_CAP_HEADER = 12'h330;
	localparam logic [11:0] OFS_CAPABILITY = 12'h334;
	localparam logic [11:0] OFS_CONTROL = 12'h336;
	localparam logic [11:0] OFS_BASE_LOW = 12'h338;
	localparam logic [11:0] OFS_BASE_HIGH = 12'h33c;
	localparam logic [11:0] OFS_RECV_LOW = 12'h340;
	localparam logic [11:0] OFS_RECV_HIGH = 12'h344;
	// Fixed header identity values.
	localparam logic [15:0] CAP_ID = 16'h0012;
	localparam logic [3:0] CAP_VERSION = 4'h1;
	// Field positions and widths.
	localparam int PTR_LSB = 20;
	localparam int PTR_W = 12;
	localparam int GROUP_W = 6;
	localparam int FLAG_BIT = 15;
	localparam int BASE_LOW_LSB = 12;
	localparam int BASE_LOW_W = 20;
	localparam int ADDR_W = 64;
	// Reset values.
	localparam logic [5:0] MAX_GROUP_RST = 6'h1f;
	localparam logic CRC_REGEN_RST = 1'b1;
	localparam logic [5:0] GROUP_COUNT_RST = 6'h00;
	localparam logic ENABLE_RST = 1'b0;
	localparam logic [5:0] INDEX_POS_RST = 6'h00;
	localparam logic [19:0] BASE_LOW_RST = 20'h00000;
	localparam logic [31:0] WORD_RST = 32'h00000000;
	// A memory request seen on the partition's virtual bus.
	typedef struct packed {
		logic valid;
		logic is_mem;
		logic from_this_port;
		logic [63:0] addr;
	} tlp_in_s;
	// The classification and egress decision for one request.
	typedef struct packed {
		logic multicast;
		logic forward;
		logic [5:0] group;
	} fwd_out_s;
endpackage : mcast_pkg

// ### design/multicast_capability_regs.sv
// Multicast capability registers of one switch port and its egress decision.
`timescale 1ns/10ps
// How it works
// (R1) Header low half reads identifier 0x12.
// (R2) Header bits 19:16 read version 1.
// (R3) Next pointer lockable; zero ends chain.
// (R4) Maximum group field resets to 0x1F.
// (R5) Maximum group writable while configuration unlocked.
// (R6) Supported groups equal field plus one.
// (R7) Crc regeneration bit resets one, lockable.
// (R8) Enabled groups equal count plus one.
// (R9) Software keeps count within supported maximum.
// (R10) Control bit 15 enables multicast, resets zero.
// (R11) Index position selects group number lsb.
// (R12) Software sets index position twelve or more.
// (R13) Base low stores address bits 31:12.
// (R14) Base high stores address bits 63:32.
// (R15) Software keeps base bits under group zero.
// (R16) Forward matching group unless entered here.
// (R17) Low mask bit n selects group n.
// (R18) Mask bits above enabled count ignored.
// (R19) High mask bit n selects group 32+n.
// (R20) Window hit classifies request as multicast.
module multicast_capability_regs #(
	parameter logic [11:0] NEXT_PTR_DEFAULT = 12'h000 // Chain link after reset.
) (
	input wire logic clock, // Core clock, 100 MHz.
	input wire logic reset_n, // Synchronous reset, active low.
	input wire logic config_unlock, // High while lockable fields may be written.
	input wire logic [11:0] reg_addr, // Register byte address.
	input wire logic [31:0] reg_wdata, // Write data.
	input wire logic reg_wr, // Write strobe, one cycle.
	input wire logic reg_rd, // Read strobe, one cycle.
	output logic [31:0] reg_rdata, // Read data, the cycle after the strobe.
	input wire mcast_pkg::tlp_in_s tlp, // Request under classification.
	output logic fwd_valid, // Decision valid, one cycle per request.
	output mcast_pkg::fwd_out_s fwd // Decision for the request.
);

	// The lock is a plain input: whoever sequences initial configuration raises it while
	// the header pointer, the group maximum and the crc flag may still be changed, and
	// drops it before normal operation. Locked writes are dropped without any error.
	// Lockable header and capability fields.
	logic [11:0] next_capability_pointer_ff; // Next capability link.
	logic [5:0] max_supported_groups_ff; // Supported groups minus one.
	logic crc_regen_supported_ff; // Crc regeneration advertised.
	// Control fields.
	logic [5:0] enabled_group_count_ff; // Enabled groups minus one.
	logic multicast_global_enable_ff; // Multicast handling on.
	// Window base and group index.
	logic [5:0] group_index_position_ff; // Group number lsb in the address.
	logic [19:0] window_base_low_ff; // Base address bits 31:12.
	logic [31:0] window_base_high_ff; // Base address bits 63:32.
	// Receive masks for groups 0 to 31 and 32 to 63.
	logic [31:0] group_receive_mask_low_ff; // Lower groups.
	logic [31:0] group_receive_mask_high_ff; // Upper groups.
	// Bus answer and decision registers.
	logic [31:0] reg_rdata_ff; // Registered read answer.
	logic fwd_valid_ff; // Registered decision strobe.
	mcast_pkg::fwd_out_s fwd_ff; // Registered decision.

	// Address decode of each register.
	wire sel_header = (reg_addr == mcast_pkg::OFS_CAP_HEADER);
	wire sel_cap = (reg_addr == mcast_pkg::OFS_CAPABILITY);
	wire sel_ctl = (reg_addr == mcast_pkg::OFS_CONTROL);
	wire sel_base_low = (reg_addr == mcast_pkg::OFS_BASE_LOW);
	wire sel_base_high = (reg_addr == mcast_pkg::OFS_BASE_HIGH);
	wire sel_recv_low = (reg_addr == mcast_pkg::OFS_RECV_LOW);
	wire sel_recv_high = (reg_addr == mcast_pkg::OFS_RECV_HIGH);

	// Write enables; lockable fields also need the unlock input.
	wire wr_header = reg_wr && sel_header && config_unlock;
	wire wr_cap = reg_wr && sel_cap && config_unlock;
	wire wr_ctl = reg_wr && sel_ctl;
	wire wr_base_low = reg_wr && sel_base_low;
	wire wr_base_high = reg_wr && sel_base_high;
	wire wr_recv_low = reg_wr && sel_recv_low;
	wire wr_recv_high = reg_wr && sel_recv_high;

	// Write data slices per field.
	wire [11:0] wd_ptr = reg_wdata[mcast_pkg::PTR_LSB +: mcast_pkg::PTR_W];
	wire [5:0] wd_group = reg_wdata[0 +: mcast_pkg::GROUP_W];
	wire wd_flag = reg_wdata[mcast_pkg::FLAG_BIT];
	wire [19:0] wd_base = reg_wdata[mcast_pkg::BASE_LOW_LSB +: mcast_pkg::BASE_LOW_W];

	// Read views; reserved bits and bits above 16-bit registers are zero.
	// (R1) Identifier in the low half.
	// (R2) Fixed version above it.
	wire [31:0] rv_header = {next_capability_pointer_ff, mcast_pkg::CAP_VERSION,
		mcast_pkg::CAP_ID};
	// Capability word: crc flag on bit 15, the group maximum at the bottom.
	wire [31:0] rv_cap = {16'h0000, crc_regen_supported_ff, 9'h000,
		max_supported_groups_ff};
	// Control word: enable on bit 15, the enabled group count at the bottom.
	wire [31:0] rv_ctl = {16'h0000, multicast_global_enable_ff, 9'h000,
		enabled_group_count_ff};
	// (R13) Bits 11:6 read zero.
	wire [31:0] rv_base_low = {window_base_low_ff, 6'h00, group_index_position_ff};

	// Read selection; an unmapped address answers zero.
	wire [31:0] rd_mux = sel_header ? rv_header :
		sel_cap ? rv_cap :
		sel_ctl ? rv_ctl :
		sel_base_low ? rv_base_low :
		sel_base_high ? window_base_high_ff :
		sel_recv_low ? group_receive_mask_low_ff :
		sel_recv_high ? group_receive_mask_high_ff :
		mcast_pkg::WORD_RST;

	// Header pointer, held unless configuration is unlocked.
	always_ff @(posedge clock)
	begin
		// Reset loads the chain link chosen at build time.
		if (!reset_n)
			next_capability_pointer_ff <= NEXT_PTR_DEFAULT;
		// (R3) Lockable pointer write.
		else if (wr_header)
			next_capability_pointer_ff <= wd_ptr;
	end

	// Capability fields, writable only while unlocked.
	always_ff @(posedge clock)
	begin
		// (R4) Default of 32 groups.
		if (!reset_n)
		begin
			max_supported_groups_ff <= mcast_pkg::MAX_GROUP_RST;
			crc_regen_supported_ff <= mcast_pkg::CRC_REGEN_RST;
		end
		// (R5) Raise to 64 groups.
		// (R7) Lockable crc flag.
		else if (wr_cap)
		begin
			max_supported_groups_ff <= wd_group;
			crc_regen_supported_ff <= wd_flag;
		end
	end

	// Control register, freely writable.
	always_ff @(posedge clock)
	begin
		// (R8) Count resets zero.
		// (R10) Enable resets zero.
		if (!reset_n)
		begin
			enabled_group_count_ff <= mcast_pkg::GROUP_COUNT_RST;
			multicast_global_enable_ff <= mcast_pkg::ENABLE_RST;
		end
		// The control register has no lock.
		else if (wr_ctl)
		begin
			enabled_group_count_ff <= wd_group;
			multicast_global_enable_ff <= wd_flag;
		end
	end

	// Base address low word with the index position.
	always_ff @(posedge clock)
	begin
		// Reset clears the window base and the index.
		if (!reset_n)
		begin
			group_index_position_ff <= mcast_pkg::INDEX_POS_RST;
			window_base_low_ff <= mcast_pkg::BASE_LOW_RST;
		end
		// (R13) Store bits 31:12.
		else if (wr_base_low)
		begin
			group_index_position_ff <= wd_group;
			window_base_low_ff <= wd_base;
		end
	end

	// Base high word and the two receive masks.
	always_ff @(posedge clock)
	begin
		// Reset clears the high base and both masks.
		if (!reset_n)
		begin
			window_base_high_ff <= mcast_pkg::WORD_RST;
			group_receive_mask_low_ff <= mcast_pkg::WORD_RST;
			group_receive_mask_high_ff <= mcast_pkg::WORD_RST;
		end
		// Each word has its own write enable.
		else
		begin
			// (R14) Store bits 63:32.
			if (wr_base_high)
				window_base_high_ff <= reg_wdata;
			// (R17) Full read-write mask.
			if (wr_recv_low)
				group_receive_mask_low_ff <= reg_wdata;
			// (R19) Upper group mask.
			if (wr_recv_high)
				group_receive_mask_high_ff <= reg_wdata;
		end
	end

	// Read answer stands only in the cycle after the strobe.
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			reg_rdata_ff <= mcast_pkg::WORD_RST;
		// A read strobe captures the selected register.
		else if (reg_rd)
			reg_rdata_ff <= rd_mux;
		// Otherwise the answer falls back to zero.
		else
			reg_rdata_ff <= mcast_pkg::WORD_RST;
	end

	// Egress decision. The request address is taken relative to the window base, so an
	// address below the base shows up as a borrow in the top bit of the difference and
	// can never alias onto a low group. Software keeps the base clear below the index
	// position and across the group field, so the shifted offset is the group number.
	// A request that lands beyond group 63 leaves bits above the group field set.
	// Full 64-bit window base; the low twelve bits are always zero.
	wire [63:0] window_base = {window_base_high_ff, window_base_low_ff, 12'h000};
	// Offset into the window; the top bit flags an address below the base.
	wire [64:0] window_offset = {1'b0, tlp.addr} - {1'b0, window_base};
	// (R11) Group number starts at the index position.
	wire [63:0] group_field = window_offset[63:0] >> group_index_position_ff;
	wire [5:0] group_num = group_field[5:0];
	// Groups beyond 63 would need address bits above the group field.
	wire group_in_range = (group_field[63:6] == 58'h0) && !window_offset[64];
	// Both group fields hold a count minus one; this widens and adds the one back.
	function automatic logic [6:0] groups_of(input logic [5:0] field);
		// The extra top bit keeps a field of 63 from wrapping to zero.
		return {1'b0, field} + 7'h01;
	endfunction : groups_of

	// (R6) Supported groups are the field plus one.
	wire [6:0] supported_groups = groups_of(max_supported_groups_ff);
	// (R8) Enabled groups are the count plus one.
	wire [6:0] active_groups = groups_of(enabled_group_count_ff);
	// A group is active only below both limits.
	wire group_active = ({1'b0, group_num} < active_groups) &&
		({1'b0, group_num} < supported_groups);
	// (R20) Window hit while enabled marks multicast.
	wire is_multicast = tlp.valid && tlp.is_mem && multicast_global_enable_ff &&
		group_in_range && group_active;
	// Both mask words side by side, group n at bit n.
	wire [63:0] receive_mask = {group_receive_mask_high_ff, group_receive_mask_low_ff};
	// (R16) Forward unless it came in here.
	// (R18) Inactive groups never forward.
	wire forward_now = is_multicast && receive_mask[group_num] && !tlp.from_this_port;

	// Decision register, one cycle after the request.
	always_ff @(posedge clock)
	begin
		// Reset drops any decision in flight.
		if (!reset_n)
		begin
			fwd_valid_ff <= 1'b0;
			fwd_ff <= '0;
		end
		// A decision is formed every cycle; the strobe marks the real ones.
		else
		begin
			fwd_valid_ff <= tlp.valid;
			fwd_ff.multicast <= is_multicast;
			fwd_ff.forward <= forward_now;
			fwd_ff.group <= group_num;
		end
	end

	// Outputs come straight from the registers above.
	assign reg_rdata = reg_rdata_ff;
	assign fwd_valid = fwd_valid_ff;
	assign fwd = fwd_ff;

	// Checks of the register behaviour and the egress decision.
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	// Attempts that start in reset are dropped, so the first edge after it is checked.

	// A header read returns the identifier and version next cycle.
	AST_HDR_ID: assert property (reg_rd && sel_header |=> // (R1)
		reg_rdata[15:0] == mcast_pkg::CAP_ID)
		else $error("Header identifier wrong.");
	AST_HDR_VER: assert property (reg_rd && sel_header |=> // (R2)
		reg_rdata[19:16] == mcast_pkg::CAP_VERSION)
		else $error("Header version wrong.");
	// A locked header write leaves the pointer alone.
	AST_PTR_LOCK: assert property (reg_wr && sel_header && !config_unlock |=> // (R3)
		$stable(next_capability_pointer_ff))
		else $error("Pointer changed while locked.");
	// Right after reset the capability shows its defaults.
	AST_CAP_RESET: assert property (!$past(reset_n) |-> // (R4)
		max_supported_groups_ff == mcast_pkg::MAX_GROUP_RST && crc_regen_supported_ff)
		else $error("Capability reset value wrong.");
	// An unlocked write lands in the maximum group field next cycle.
	AST_MAXG_WRITE: assert property (wr_cap |=> // (R5)
		max_supported_groups_ff == $past(wd_group))
		else $error("Maximum group write lost.");
	// A forwarded group never exceeds the supported count.
	AST_SUPPORTED: assert property (fwd_valid && fwd.forward |-> // (R6)
		{1'b0, fwd.group} <= $past(max_supported_groups_ff))
		else $error("Group above supported maximum forwarded.");
	AST_CRC_LOCK: assert property (reg_wr && sel_cap && !config_unlock |=> // (R7)
		$stable(crc_regen_supported_ff) && $stable(max_supported_groups_ff))
		else $error("Capability changed while locked.");
	// Without the enable nothing is multicast.
	AST_NO_ENABLE: assert property (!multicast_global_enable_ff |=> // (R10)
		!fwd.multicast && !fwd.forward)
		else $error("Multicast seen while disabled.");
	AST_LOW_RSV: assert property (reg_rd && sel_base_low |=> // (R13)
		reg_rdata[11:6] == 6'h00)
		else $error("Reserved base bits not zero.");
	// A request from this port is never sent back out of it.
	AST_OWN_PORT: assert property (tlp.valid && tlp.from_this_port |=> // (R16)
		fwd_valid && !fwd.forward)
		else $error("Own request forwarded.");
	// A request whose group mask bit is clear is never forwarded.
	AST_MASK_BIT: assert property (tlp.valid && !receive_mask[group_num] |=> // (R17)
		!fwd.forward)
		else $error("Forward without mask bit.");
	// Groups above the enabled count never forward.
	AST_ABOVE_COUNT: assert property (fwd_valid && fwd.forward |-> // (R18)
		fwd.group <= $past(enabled_group_count_ff))
		else $error("Group above enabled count forwarded.");

	// Unlocked header and capability writes land as written.
	AST_PTR_WRITE: assert property (wr_header |=> // (R3)
		next_capability_pointer_ff == $past(wd_ptr))
		else $error("Pointer write lost.");
	AST_CRC_WRITE: assert property (wr_cap |=> // (R7)
		crc_regen_supported_ff == $past(wd_flag))
		else $error("Crc flag write lost.");
	// Right after reset the control register is cleared.
	AST_CTL_RESET: assert property (!$past(reset_n) |-> // (R8)
		enabled_group_count_ff == mcast_pkg::GROUP_COUNT_RST && !multicast_global_enable_ff)
		else $error("Control reset value wrong.");
	// Control writes land in the count and the enable.
	AST_COUNT_SET: assert property (wr_ctl |=> // (R8)
		enabled_group_count_ff == $past(wd_group))
		else $error("Group count write lost.");
	AST_ENABLE_SET: assert property (wr_ctl |=> // (R10)
		multicast_global_enable_ff == $past(wd_flag))
		else $error("Enable write lost.");
	// One step of the index position is one group.
	AST_INDEX_LSB: assert property (tlp.valid && // (R11)
		tlp.addr == window_base + (64'h1 << group_index_position_ff) |=>
		fwd.group == 6'h01)
		else $error("Index position does not select the group lsb.");
	// Base and mask words store what was written.
	AST_BASE_LOW: assert property (wr_base_low |=> // (R13)
		window_base_low_ff == $past(wd_base))
		else $error("Base low write lost.");
	AST_BASE_HIGH: assert property (wr_base_high |=> // (R14)
		window_base_high_ff == $past(reg_wdata))
		else $error("Base high write lost.");
	AST_RECV_LOW: assert property (wr_recv_low |=> // (R17)
		group_receive_mask_low_ff == $past(reg_wdata))
		else $error("Low mask write lost.");
	AST_RECV_HIGH: assert property (wr_recv_high |=> // (R19)
		group_receive_mask_high_ff == $past(reg_wdata))
		else $error("High mask write lost.");
	// Only memory requests can be multicast.
	AST_NOT_MEM: assert property (tlp.valid && !tlp.is_mem |=> // (R20)
		fwd_valid && !fwd.multicast)
		else $error("Non-memory request seen as multicast.");
	// A decision strobe follows only a real request.
	AST_FWD_PULSE: assert property (!tlp.valid |=> // (R16)
		!fwd_valid)
		else $error("Decision strobe without request.");

	// Main scenarios.
	COV_FORWARD: cover property (fwd_valid && fwd.forward);
	COV_UPPER_GROUP: cover property (fwd_valid && fwd.forward && fwd.group[5]);
	COV_MAX_RAISED: cover property (wr_cap && wd_group == 6'h3f);
	COV_MASKED: cover property (fwd_valid && fwd.multicast && !fwd.forward);
	COV_OWN_BLOCKED: cover property (tlp.valid && tlp.from_this_port && is_multicast);

endmodule : multicast_capability_regs

// ### tb/multicast_capability_regs_bench.sv
// Self-checking bench for the multicast capability register block.
`timescale 1ns/10ps
module multicast_capability_regs_bench;
	logic clock; // Core clock, 100 MHz.
	logic reset_n; // Synchronous reset, active low.
	logic config_unlock; // Opens the lockable fields.
	logic [11:0] reg_addr; // Register byte address.
	logic [31:0] reg_wdata; // Write data.
	logic reg_wr; // Write strobe.
	logic reg_rd; // Read strobe.
	logic [31:0] reg_rdata; // Read data.
	mcast_pkg::tlp_in_s tlp; // Request under test.
	logic fwd_valid; // Decision strobe.
	mcast_pkg::fwd_out_s fwd; // Decision.
	int n_fail; // Mismatches seen.
	int checked; // Comparisons made.
	// Window base used by the forwarding tests, index position 12.
	localparam logic [63:0] BASE = 64'h0000_0001_0010_0000;

	multicast_capability_regs i_dut (
		.clock(clock),
		.reset_n(reset_n),
		.config_unlock(config_unlock),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.tlp(tlp),
		.fwd_valid(fwd_valid),
		.fwd(fwd)
	);

	// The clock toggles every half period.
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Compares one value and counts the outcome.
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Prints the verdict and ends the run.
	task close_out();
		if (n_fail == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	// One write cycle on the register port.
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	// One read cycle; the data are looked at in the following cycle only.
	task rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask : rd

	// Address of group g inside the window.
	function automatic logic [63:0] ga(input int g);
		return BASE + (64'(g) << 12);
	endfunction : ga

	// Offers one request and checks the decision one cycle later.
	task send(input logic mem, input logic own, input logic [63:0] a, input logic [7:0] exp);
		@(posedge clock);
		tlp <= '{valid: 1'b1, is_mem: mem, from_this_port: own, addr: a};
		@(posedge clock);
		tlp <= '0;
		#1;
		check({31'h0, fwd_valid}, 32'h1);
		check({24'h0, fwd}, {24'h0, exp});
	endtask : send

	// A hang is cut short and counted as a mismatch.
	initial
	begin
		repeat (5000) @(posedge clock);
		n_fail++;
		close_out();
	end

	// Main sequence.
	initial
	begin
		n_fail = 0;
		checked = 0;
		reset_n = 1'b0;
		config_unlock = 1'b0;
		reg_addr = 12'h000;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		tlp = '0;
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		// Reset values of every register, and an unmapped place.
		rd(12'h330, 32'h00010012);
		rd(12'h334, 32'h0000801f);
		rd(12'h336, 32'h00000000);
		rd(12'h338, 32'h00000000);
		rd(12'h33c, 32'h00000000);
		rd(12'h340, 32'h00000000);
		rd(12'h344, 32'h00000000);
		rd(12'h348, 32'h00000000);
		// Read data stand one cycle only.
		@(posedge clock);
		#1;
		check(reg_rdata, 32'h0);
		// Lockable fields refuse writes while locked.
		wr(12'h330, 32'hfff00000);
		rd(12'h330, 32'h00010012);
		wr(12'h334, 32'h0000003f);
		rd(12'h334, 32'h0000801f);
		// Unlocked, pointer, group maximum and crc flag take writes.
		@(posedge clock);
		config_unlock <= 1'b1;
		wr(12'h330, 32'habcfffff);
		rd(12'h330, 32'habc10012);
		wr(12'h334, 32'hffff7fff);
		rd(12'h334, 32'h0000003f);
		@(posedge clock);
		config_unlock <= 1'b0;
		wr(12'h334, 32'h00008000);
		rd(12'h334, 32'h0000003f);
		// Read-write fields, reserved bits held at zero.
		wr(12'h336, 32'hffffffff);
		rd(12'h336, 32'h0000803f);
		wr(12'h338, 32'hffffffff);
		rd(12'h338, 32'hfffff03f);
		wr(12'h33c, 32'hffffffff);
		rd(12'h33c, 32'hffffffff);
		wr(12'h340, 32'ha5a5a5a5);
		rd(12'h340, 32'ha5a5a5a5);
		wr(12'h344, 32'h5a5a5a5a);
		rd(12'h344, 32'h5a5a5a5a);
		wr(12'h348, 32'hffffffff);
		rd(12'h348, 32'h00000000);
		// Window set up with four enabled groups; groups 0, 2, 5 and 33 received.
		wr(12'h338, 32'h0010000c);
		wr(12'h33c, 32'h00000001);
		wr(12'h340, 32'h00000025);
		wr(12'h344, 32'h00000002);
		wr(12'h336, 32'h00008003);
		send(1'b1, 1'b0, ga(0), 8'hc0);
		send(1'b1, 1'b0, ga(1), 8'h81);
		send(1'b1, 1'b1, ga(2), 8'h82);
		send(1'b1, 1'b0, ga(5), 8'h05);
		send(1'b0, 1'b0, ga(0), 8'h00);
		send(1'b1, 1'b0, BASE - 64'h1000, 8'h3f);
		// All sixty-four groups enabled; the upper mask is used.
		wr(12'h336, 32'h0000803f);
		send(1'b1, 1'b0, ga(33), 8'he1);
		send(1'b1, 1'b0, ga(34), 8'ha2);
		send(1'b1, 1'b0, ga(5), 8'hc5);
		// Index moved up by one: each group now spans two 4 KiB steps.
		wr(12'h338, 32'h0010000d);
		send(1'b1, 1'b0, ga(2), 8'h81);
		send(1'b1, 1'b0, ga(10), 8'hc5);
		wr(12'h338, 32'h0010000c);
		// Global enable off: nothing is multicast.
		wr(12'h336, 32'h0000003f);
		send(1'b1, 1'b0, ga(33), 8'h21);
		// A decision strobe stands for one cycle only.
		@(posedge clock);
		#1;
		check({31'h0, fwd_valid}, 32'h0);
		// A reset in mid-run restores the header, capability, control and low mask defaults, lock or no lock.
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		rd(12'h330, 32'h00010012);
		rd(12'h334, 32'h0000801f);
		rd(12'h336, 32'h00000000);
		rd(12'h340, 32'h00000000);
		close_out();
	end
endmodule : multicast_capability_regs_bench
